// ==== common/macu_pkg.sv ====
package macu_pkg;

  // Byte offsets of the special function registers
  localparam logic [7:0] MACU_OFF_TOP  = 8'h06;
  localparam logic [7:0] MACU_OFF_MODE = 8'h0b;
  localparam logic [7:0] MACU_OFF_LOW  = 8'h0c;
  localparam logic [7:0] MACU_OFF_HIGH = 8'h0e;

  // Mode and flag register layout and reset value
  localparam logic [7:0] MACU_MODE_RESET = 8'h38;
  localparam int MACU_FRAC_BIT  = 7;
  localparam int MACU_SAT_BIT   = 6;
  localparam int MACU_STICKY_OVERFLOW_FLAG_BIT = 2;
  localparam int MACU_OVF_BIT   = 1;
  localparam int MACU_STICKY_SATURATION_FLAG_BIT = 0;

  // Accumulator reset value and saturation limits
  localparam logic [39:0] MACU_ACC_RESET = 40'h00_0000_0000;
  localparam logic [31:0] MACU_SAT_POS   = 32'h7fff_ffff;
  localparam logic [31:0] MACU_SAT_NEG   = 32'h8000_0000;

  // Register arithmetic and long operations on the accumulator
  typedef enum logic [2:0] {
    MACU_ADD_LOW   = 3'b000,
    MACU_SUB_LOW   = 3'b001,
    MACU_ADD_WITH_CARRY_OP_HIGH = 3'b010,
    MACU_SUBTRACT_WITH_BORROW_OP_HIGH = 3'b011,
    MACU_LONG_CMP  = 3'b100,
    MACU_LONG_SHL  = 3'b101,
    MACU_LONG_SHRA = 3'b110,
    MACU_LONG_NORM = 3'b111
  } macu_alu_op_type;

  // Special function register access from the core
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        is_byte;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } macu_sfr_req_type;

  // One accumulation step with the product already formed
  typedef struct packed {
    logic        valid;
    logic        is_signed;
    logic        subtract;
    logic        zeroed;
    logic [31:0] product;
  } macu_mac_req_type;

  // One register arithmetic or long operation
  typedef struct packed {
    logic            valid;
    macu_alu_op_type op;
    logic [31:0]     operand;
    logic [4:0]      count;
  } macu_alu_req_type;

endpackage : macu_pkg

// ==== logic/macu_core.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - Accumulator is 40 bits: two words plus byte
// - Top byte holds true sum only unsigned unsaturated
// - Words at 0CH, 0EH and byte at 06H
// - Reads return live value; writes overwrite portion
// - Mode bits ignored for unsigned multiplication
// - Fractional mode shifts signed product left once
// - Saturation mode clamps signed accumulation
// - Unsigned carry out of bit 31 sets sticky
// - Signed sign overflow sets both overflow flags unless saturating
// - Overflow flag re-evaluated on every accumulation
// - Saturation sets the sticky saturation flag
// - Sticky flags cleared only by software write or reset
// - Clamp to 80000000H or 7FFFFFFFH
// - Accumulation continues normally after saturation
// - Add/sub low word, carry forms high word
// - Only 32-bit quantities via register arithmetic
// - Top byte only by byte access and MAC
// - Low 32 bits take MAC, words, long ops
module macu_core
  import macu_pkg::*;
#(
  parameter int unsigned TOP_BITS = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_nrst,
  input  wire logic             i_clk_en,
  input  wire macu_sfr_req_type i_sfr,
  input  wire macu_mac_req_type i_mac,
  input  wire macu_alu_req_type i_alu,
  output logic [15:0]           o_sfr_rdata,
  output logic                  o_sfr_ack,
  output logic                  o_sfr_err,
  output logic [39:0]           o_acc,
  output logic [7:0]            o_mode,
  output logic                  o_carry,
  output logic                  o_cmp_zero,
  output logic                  o_cmp_less,
  output logic [4:0]            o_norm_shift
);

  // The datapath is built for a one-byte extension only
  if (TOP_BITS != 8) begin : g_bad_width
    $error("macu_core: TOP_BITS must be 8");
  end

  // Exact offset match, shared by every decode below
  function automatic logic f_at(input logic [7:0] a,
                                input logic [7:0] off);
    return a == off;
  endfunction : f_at

  // Shifts needed to bring the first one into bit 31
  function automatic logic [4:0] f_lead(input logic [31:0] x);
    logic [4:0] n;
    n = 5'd0;
    for (int i = 0; i < 32; i++) begin
      if (x[i]) begin
        n = 5'(31 - i);
      end
    end
    return n;
  endfunction : f_lead

  // State
  logic [39:0] acc;
  logic        frac_en;
  logic        sat_en;
  logic        st_ovf;
  logic        last_ovf;
  logic        st_sat;
  logic        carry;

  // Register decode; top byte refuses word access
  wire logic hit_low  =
    f_at(i_sfr.addr, MACU_OFF_LOW) & ~i_sfr.is_byte;
  wire logic hit_high =
    f_at(i_sfr.addr, MACU_OFF_HIGH) & ~i_sfr.is_byte;
  wire logic hit_top  =
    f_at(i_sfr.addr, MACU_OFF_TOP) & i_sfr.is_byte;
  wire logic hit_mode = f_at(i_sfr.addr, MACU_OFF_MODE) & i_sfr.is_byte;
  wire logic hit_any  = hit_low | hit_high | hit_top | hit_mode;
  wire logic access   = i_sfr.rd | i_sfr.wr;

  wire logic wr_low  = i_sfr.wr & hit_low;
  wire logic wr_high = i_sfr.wr & hit_high;
  wire logic wr_top  = i_sfr.wr & hit_top;
  wire logic wr_mode = i_sfr.wr & hit_mode;
  wire logic wr_acc  = wr_low | wr_high | wr_top;

  // Reserved bits are not stored; they read back as after reset
  wire logic [7:0] mode_view = {frac_en, sat_en,
                                MACU_MODE_RESET[5:3],
                                st_ovf, last_ovf, st_sat};

  // Byte writes land in the low lane
  wire logic [39:0] wr_acc_val =
    wr_low  ? {acc[39:16], i_sfr.wdata} :
    wr_high ? {acc[39:32], i_sfr.wdata, acc[15:0]} :
              {i_sfr.wdata[7:0], acc[31:0]};

  wire logic [15:0] rd_val =
    hit_low  ? acc[15:0] :
    hit_high ? acc[31:16] :
    hit_top  ? {8'h00, acc[39:32]} :
               {8'h00, mode_view};

  // Modes act only on signed products
  wire logic frac_on = i_mac.is_signed & frac_en;
  wire logic sat_on  = i_mac.is_signed & sat_en;

  // Zeroing variants start from an empty accumulator
  wire logic [39:0] base40 = i_mac.zeroed ? MACU_ACC_RESET : acc;
  wire logic [31:0] base   = base40[31:0];

  // Unsigned path carries into the top byte
  wire logic [39:0] uns_add = {8'h00, i_mac.product};
  wire logic [39:0] uns_sum = i_mac.subtract ? base40 - uns_add
                                             : base40 + uns_add;
  wire logic [32:0] uns_low = i_mac.subtract
    ? {1'b0, base} - {1'b0, i_mac.product}
    : {1'b0, base} + {1'b0, i_mac.product};
  wire logic uns_carry = uns_low[32];

  // Signed path: fractional shift drops the duplicate sign bit
  wire logic [31:0] prod_sh = frac_on ? {i_mac.product[30:0], 1'b0}
                                      : i_mac.product;
  wire logic [31:0] addend  = i_mac.subtract ? 32'(-prod_sh) : prod_sh;
  wire logic [31:0] sgn_sum = base + addend;

  // Same input signs, result sign flipped
  wire logic sgn_ovf = (base[31] == addend[31]) &
                       (sgn_sum[31] != base[31]);

  // Clamp follows the sign of the operands that overflowed
  wire logic        do_sat  = sgn_ovf & sat_on;
  wire logic [31:0] sat_val = base[31] ? MACU_SAT_NEG
                                       : MACU_SAT_POS;
  wire logic [31:0] sgn_res = do_sat ? sat_val : sgn_sum;

  // Top byte is undefined for signed; sign-extension keeps it tidy
  wire logic [39:0] mac_acc = i_mac.is_signed
    ? {{8{sgn_res[31]}}, sgn_res}
    : uns_sum;

  // Flag events of this accumulation
  wire logic ev_ovf = i_mac.is_signed ? (sgn_ovf & ~sat_on)
                                      : uns_carry;
  wire logic ev_sat = i_mac.valid & do_sat;
  wire logic ev_st  = i_mac.valid & ev_ovf;

  // Word arithmetic; carry flag set means no borrow
  wire logic alu_sub  = (i_alu.op == MACU_SUB_LOW) |
                        (i_alu.op == MACU_SUBTRACT_WITH_BORROW_OP_HIGH);
  wire logic alu_high = (i_alu.op == MACU_ADD_WITH_CARRY_OP_HIGH) |
                        (i_alu.op == MACU_SUBTRACT_WITH_BORROW_OP_HIGH);
  wire logic alu_word = ~i_alu.op[2];
  wire logic [15:0] w_in  = alu_high ? acc[31:16] : acc[15:0];
  wire logic [15:0] w_opx = alu_sub ? ~i_alu.operand[15:0]
                                    : i_alu.operand[15:0];
  wire logic        w_cin = alu_high ? carry : alu_sub;
  wire logic [16:0] w_sum = {1'b0, w_in} + {1'b0, w_opx}
                            + {16'h0000, w_cin};

  // Long operations on the low 32 bits
  wire logic [31:0] lo      = acc[31:0];
  wire logic [31:0] l_shl   = lo << i_alu.count;
  wire logic [31:0] l_shra  = 32'($signed(lo) >>> i_alu.count);
  wire logic [4:0]  l_nsh   = f_lead(lo);
  wire logic [31:0] l_norm  = lo << l_nsh;
  wire logic [32:0] l_diff  = {1'b0, lo} - {1'b0, i_alu.operand};
  wire logic        l_less  = $signed(lo) < $signed(i_alu.operand);
  wire logic        is_cmp  = i_alu.op == MACU_LONG_CMP;
  wire logic        is_norm = i_alu.op == MACU_LONG_NORM;

  // Top byte never changes on register arithmetic
  wire logic [31:0] alu_lo =
    (i_alu.op == MACU_LONG_SHL)  ? l_shl :
    (i_alu.op == MACU_LONG_SHRA) ? l_shra :
    is_norm  ? l_norm :
    is_cmp   ? lo :
    alu_high ? {w_sum[15:0], acc[15:0]} :
               {acc[31:16], w_sum[15:0]};

  // Accumulator register writes outrank operations in the same cycle
  wire logic [39:0] next_acc =
    wr_acc      ? wr_acc_val :
    i_mac.valid ? mac_acc :
    i_alu.valid ? {acc[39:32], alu_lo} :
                  acc;

  // Software write loads flags, hardware set wins the same cycle
  wire logic next_st_ovf =
    (wr_mode ? i_sfr.wdata[MACU_STICKY_OVERFLOW_FLAG_BIT] : st_ovf) | ev_st;
  wire logic next_st_sat =
    (wr_mode ? i_sfr.wdata[MACU_STICKY_SATURATION_FLAG_BIT] : st_sat) | ev_sat;
  wire logic next_last_ovf =
    i_mac.valid ? ev_ovf :
    wr_mode     ? i_sfr.wdata[MACU_OVF_BIT] :
                  last_ovf;

  // Borrow from compare follows the same sense as subtraction
  wire logic next_carry =
    ~i_alu.valid ? carry :
    alu_word     ? w_sum[16] :
    is_cmp       ? ~l_diff[32] :
                   carry;

  // Accumulator and carry
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      acc   <= MACU_ACC_RESET;
      carry <= 1'b0;
    end else if (i_clk_en) begin
      acc   <= next_acc;
      carry <= next_carry;
    end
  end

  // Mode bits; reserved bits take no write
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      frac_en <= MACU_MODE_RESET[MACU_FRAC_BIT];
      sat_en  <= MACU_MODE_RESET[MACU_SAT_BIT];
    end else if (i_clk_en && wr_mode) begin
      frac_en <= i_sfr.wdata[MACU_FRAC_BIT];
      sat_en  <= i_sfr.wdata[MACU_SAT_BIT];
    end
  end

  // Status flags
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ovf   <= MACU_MODE_RESET[MACU_STICKY_OVERFLOW_FLAG_BIT];
      last_ovf <= MACU_MODE_RESET[MACU_OVF_BIT];
      st_sat   <= MACU_MODE_RESET[MACU_STICKY_SATURATION_FLAG_BIT];
    end else if (i_clk_en) begin
      st_ovf   <= next_st_ovf;
      last_ovf <= next_last_ovf;
      st_sat   <= next_st_sat;
    end
  end

  // Register bus answers, one cycle after the access
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sfr_rdata <= 16'h0000;
      o_sfr_ack   <= 1'b0;
      o_sfr_err   <= 1'b0;
    end else if (i_clk_en) begin
      if (i_sfr.rd && hit_any) begin
        o_sfr_rdata <= rd_val;
      end
      o_sfr_ack <= access & hit_any;
      o_sfr_err <= access & ~hit_any;
    end
  end

  // Compare and normalize results for the core
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cmp_zero   <= 1'b0;
      o_cmp_less   <= 1'b0;
      o_norm_shift <= 5'd0;
    end else if (i_clk_en && i_alu.valid) begin
      if (is_cmp) begin
        o_cmp_zero <= l_diff[31:0] == 32'h0000_0000;
        o_cmp_less <= l_less;
      end
      if (is_norm) begin
        o_norm_shift <= l_nsh;
      end
    end
  end

  // Live copies load the same next values as the state, so they match it every cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_acc   <= MACU_ACC_RESET;
      o_mode  <= MACU_MODE_RESET;
      o_carry <= 1'b0;
    end else if (i_clk_en) begin
      o_acc   <= next_acc;
      o_mode  <= {next_frac(), next_sat(), MACU_MODE_RESET[5:3],
                  next_st_ovf, next_last_ovf, next_st_sat};
      o_carry <= next_carry;
    end
  end

  // Mode bit next values, used by the live copy only
  function automatic logic next_frac();
    return wr_mode ? i_sfr.wdata[MACU_FRAC_BIT] : frac_en;
  endfunction : next_frac

  function automatic logic next_sat();
    return wr_mode ? i_sfr.wdata[MACU_SAT_BIT] : sat_en;
  endfunction : next_sat

endmodule : macu_core

// ==== sim/macu_cpu_model.sv ====
`timescale 1ns/100ps
// Core side: one request at a time, then scrambled lines
module macu_cpu_model
  import macu_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_sfr_ack,
  input  wire logic        i_sfr_err,
  input  wire logic [15:0] i_sfr_rdata,
  output macu_sfr_req_type o_sfr,
  output macu_mac_req_type o_mac,
  output macu_alu_req_type o_alu
);
  // Quiet from time zero
  initial begin
    o_sfr = '0;
    o_mac = '0;
    o_alu = '0;
  end
  // Answer is sampled one edge after the take edge
  task automatic sfr(input logic w, input logic [7:0] a, input logic b,
                     input logic [15:0] d, output logic [17:0] r);
    @(posedge i_clk_sys);
    o_sfr <= '{~w, w, b, a,
               (a == MACU_OFF_MODE) ? d & 16'hffc7 : d};
    @(posedge i_clk_sys);
    o_sfr <= {2'b00, ~o_sfr[24:0]};
    @(posedge i_clk_sys);
    r = {i_sfr_ack, i_sfr_err, i_sfr_rdata};
  endtask : sfr
  // Released lines never keep the last value
  task automatic mac(input logic s, input logic [31:0] p,
                     input logic sub = 1'b0, input logic z = 1'b0);
    @(posedge i_clk_sys);
    o_mac <= '{1'b1, s, sub, z, p};
    @(posedge i_clk_sys);
    o_mac <= {1'b0, ~o_mac[34:0]};
    @(negedge i_clk_sys);
  endtask : mac
  task automatic alu(input macu_alu_op_type op, input logic [31:0] v,
                     input logic [4:0] c = 5'h00);
    @(posedge i_clk_sys);
    o_alu <= '{1'b1, op, v, c};
    @(posedge i_clk_sys);
    o_alu <= {1'b0, ~o_alu[39:0]};
    @(negedge i_clk_sys);
  endtask : alu
endmodule : macu_cpu_model

// ==== sim/macu_core_chk.sv ====
`timescale 1ns/100ps
module macu_core_chk
  import macu_pkg::*;
(
  input wire logic             i_clk_sys,
  input wire logic             i_nrst,
  input wire logic             i_clk_en,
  input wire macu_sfr_req_type i_sfr,
  input wire macu_mac_req_type i_mac,
  input wire macu_alu_req_type i_alu,
  input wire logic [15:0]      o_sfr_rdata,
  input wire logic             o_sfr_ack,
  input wire logic             o_sfr_err,
  input wire logic [39:0]      o_acc,
  input wire logic [7:0]       o_mode,
  input wire logic             o_carry
);
  // Expected sums from the live accumulator; writes outrank steps
  wire go = i_clk_en && !i_sfr.wr && !i_mac.subtract && !i_mac.zeroed;
  wire ms = go && i_mac.valid && i_mac.is_signed;
  wire mu = go && i_mac.valid && !i_mac.is_signed;
  wire ag = i_clk_en && !i_sfr.wr && !i_mac.valid && i_alu.valid;
  wire [15:0] lo = o_acc[15:0];
  wire [39:0] us = o_acc + {8'h00, i_mac.product};
  wire [32:0] uc = {1'b0, o_acc[31:0]} + {1'b0, i_mac.product};
  wire [31:0] sa = o_mode[7] ? {i_mac.product[30:0], 1'b0} : i_mac.product;
  wire [31:0] ss = o_acc[31:0] + sa;
  wire so = (o_acc[31] == sa[31]) && (ss[31] != o_acc[31]);
  wire [31:0] sc = o_acc[31] ? MACU_SAT_NEG : MACU_SAT_POS;
  wire [16:0] ls = {1'b0, lo} + {1'b0, i_alu.operand[15:0]};
  wire bad = !(i_sfr.addr inside {MACU_OFF_TOP, MACU_OFF_MODE,
                                  MACU_OFF_LOW, MACU_OFF_HIGH});
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  a_read_low: assert property ((i_clk_en && i_sfr.rd &&
    !i_sfr.is_byte && i_sfr.addr == MACU_OFF_LOW) |=> o_sfr_ack
    && o_sfr_rdata == $past(lo)) else $error("low read wrong");
  a_err_map: assert property ((i_clk_en && (i_sfr.rd || i_sfr.wr)
    && bad) |=> o_sfr_err && !o_sfr_ack) else $error("no error");
  a_sticky_hold: assert property ((o_mode[2] && !(i_sfr.wr
    && i_sfr.addr == MACU_OFF_MODE)) |=> o_mode[2])
    else $error("sticky lost");
  a_sat_clamp: assert property ((ms && o_mode[6] && so) |=>
    o_acc[31:0] == $past(sc) && o_mode[0]) else $error("clamp wrong");
  a_signed_sum: assert property ((ms && !o_mode[6]) |=>
    o_acc[31:0] == $past(ss) && o_mode[1] == $past(so))
    else $error("signed sum wrong");
  a_unsigned_sum: assert property (mu |=> o_acc == $past(us)
    && o_mode[1] == $past(uc[32])
    && o_mode[2] == ($past(o_mode[2]) || $past(uc[32])))
    else $error("unsigned sum wrong");
  a_alu_top: assert property (ag |=> $stable(o_acc[39:32]))
    else $error("top byte moved");
  a_add_low: assert property ((ag && i_alu.op == MACU_ADD_LOW) |=>
    {o_carry, o_acc[15:0]} == $past(ls)) else $error("add low wrong");
  c_sat: cover property (ms && o_mode[6] && so);
  c_ovf: cover property (ms && !o_mode[6] && so);
  c_err: cover property (o_sfr_err);
endmodule : macu_core_chk

bind macu_core macu_core_chk i_macu_core_chk (.i_clk_sys, .i_nrst,
  .i_clk_en, .i_sfr, .i_mac, .i_alu, .o_sfr_rdata, .o_sfr_ack,
  .o_sfr_err, .o_acc, .o_mode, .o_carry);

// ==== sim/mac_accumulator_unit_test.sv ====
`timescale 1ns/100ps
module mac_accumulator_unit_test;
  import macu_pkg::*;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  logic             clk_en = 1'b1;
  macu_sfr_req_type sfr;
  macu_mac_req_type mac;
  macu_alu_req_type alu;
  logic [15:0]      rdata;
  logic             ack;
  logic             err;
  logic             carry;
  logic [39:0]      acc;
  logic [7:0]       mode;
  logic [17:0]      r;
  logic             cmp_zero;
  logic             cmp_less;
  logic [4:0]       norm_sh;
  int               error_cnt = 0;
  int               n_tests = 0;
  // Design and the core that drives it
  macu_core i_macu_core (.i_clk_sys(clk), .i_nrst(nrst), .i_clk_en(clk_en),
    .i_sfr(sfr), .i_mac(mac), .i_alu(alu), .o_sfr_rdata(rdata),
    .o_sfr_ack(ack), .o_sfr_err(err), .o_acc(acc), .o_mode(mode),
    .o_carry(carry), .o_cmp_zero(cmp_zero), .o_cmp_less(cmp_less),
    .o_norm_shift(norm_sh));
  macu_cpu_model i_macu_cpu_model (.i_clk_sys(clk), .i_sfr_ack(ack),
    .i_sfr_err(err), .i_sfr_rdata(rdata), .o_sfr(sfr), .o_mac(mac),
    .o_alu(alu));
  // 250 MHz
  initial forever #2 clk = ~clk;
  task automatic check(input string n, input logic [39:0] s, e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic b, input logic [15:0] d);
    i_macu_cpu_model.sfr(1'b1, a, b, d, r);
    check("write answer", {38'h0, r[17:16]}, 40'h2);
  endtask : wr
  // Byte reads judge only the low byte
  task automatic rd(input string n, input logic [7:0] a, input logic b,
                    input logic [15:0] e);
    i_macu_cpu_model.sfr(1'b0, a, b, 16'h0000, r);
    check(n, {22'h0, r[17:16], r[15:8] & {8{~b}}, r[7:0]},
          {24'h2, e});
  endtask : rd
  task automatic load(input logic [39:0] v);
    wr(MACU_OFF_LOW, 1'b0, v[15:0]);
    wr(MACU_OFF_HIGH, 1'b0, v[31:16]);
    wr(MACU_OFF_TOP, 1'b1, {8'h00, v[39:32]});
  endtask : load
  task automatic t_map;
    rd("mode reset", MACU_OFF_MODE, 1'b1, 16'h0038);
    rd("top reset", MACU_OFF_TOP, 1'b1, 16'h0000);
    load(40'h9a_5678_1234);
    check("acc", acc, 40'h9a_5678_1234);
    rd("low", MACU_OFF_LOW, 1'b0, 16'h1234);
    i_macu_cpu_model.sfr(1'b0, MACU_OFF_TOP, 1'b0, 16'h0000, r);
    check("word at byte", {38'h0, r[17:16]}, 40'h1);
    i_macu_cpu_model.sfr(1'b1, 8'h20, 1'b0, 16'hffff, r);
    check("unmapped", {r[17:16], acc[37:0]}, 40'h5a_5678_1234);
  endtask : t_map
  // Mode bits set but ignored; sum grows into the top byte
  task automatic t_unsigned;
    wr(MACU_OFF_MODE, 1'b1, 16'h00c0);
    load(40'h00_ffff_ffff);
    i_macu_cpu_model.mac(1'b0, 32'h0000_0001);
    check("unsigned", acc, 40'h01_0000_0000);
    rd("unsigned flags", MACU_OFF_MODE, 1'b1, 16'h00fe);
  endtask : t_unsigned
  task automatic t_signed;
    wr(MACU_OFF_MODE, 1'b1, 16'h0000);
    load(40'h00_7fff_ffff);
    i_macu_cpu_model.mac(1'b1, 32'h0000_0001);
    check("wrap", acc[31:0], 40'h8000_0000);
    rd("ovf set", MACU_OFF_MODE, 1'b1, 16'h003e);
    i_macu_cpu_model.mac(1'b1, 32'h0000_0000);
    rd("ovf cleared", MACU_OFF_MODE, 1'b1, 16'h003c);
    wr(MACU_OFF_MODE, 1'b1, 16'h0080);
    load(40'h00_0000_0000);
    i_macu_cpu_model.mac(1'b1, 32'h0000_0003);
    check("fraction", acc[31:0], 40'h0006);
    rd("sticky cleared", MACU_OFF_MODE, 1'b1, 16'h00b8);
  endtask : t_signed
  task automatic t_sat;
    wr(MACU_OFF_MODE, 1'b1, 16'h0040);
    load(40'h00_7fff_fff0);
    i_macu_cpu_model.mac(1'b1, 32'h0000_0100);
    check("clamp high", acc[31:0], 40'h7fff_ffff);
    rd("sat flag", MACU_OFF_MODE, 1'b1, 16'h0079);
    i_macu_cpu_model.mac(1'b1, 32'hffff_ffff);
    check("leave limit", acc[31:0], 40'h7fff_fffe);
    load(40'h00_8000_0001);
    i_macu_cpu_model.mac(1'b1, 32'hffff_ff00);
    check("clamp low", acc[31:0], 40'h8000_0000);
  endtask : t_sat
  // Carry chains the low word into the high word
  task automatic t_alu;
    load(40'h55_0000_ffff);
    i_macu_cpu_model.alu(MACU_ADD_LOW, 32'h0000_0123);
    check("carry", {39'h0, carry}, 40'h1);
    i_macu_cpu_model.alu(MACU_ADD_WITH_CARRY_OP_HIGH, 32'h0000_2233);
    check("add pair", acc, 40'h55_2234_0122);
    i_macu_cpu_model.alu(MACU_SUB_LOW, 32'h0000_0123);
    i_macu_cpu_model.alu(MACU_SUBTRACT_WITH_BORROW_OP_HIGH, 32'h0000_0000);
    check("sub pair", acc, 40'h55_2233_ffff);
  endtask : t_alu
  // Long operations leave the top byte alone
  task automatic t_long;
    load(40'h11_8000_0010);
    i_macu_cpu_model.alu(MACU_LONG_CMP, 32'h8000_0010);
    check("cmp equal", {37'h0, cmp_zero, cmp_less, carry}, 40'h5);
    check("cmp keeps", acc, 40'h11_8000_0010);
    i_macu_cpu_model.alu(MACU_LONG_CMP, 32'h0000_0001);
    check("cmp less", {37'h0, cmp_zero, cmp_less, carry}, 40'h3);
    i_macu_cpu_model.alu(MACU_LONG_SHRA, 32'h0000_0000, 5'h04);
    check("shift right", acc, 40'h11_f800_0001);
    i_macu_cpu_model.alu(MACU_LONG_SHL, 32'h0000_0000, 5'h03);
    check("shift left", acc, 40'h11_c000_0008);
    wr(MACU_OFF_HIGH, 1'b0, 16'h0000);
    i_macu_cpu_model.alu(MACU_LONG_NORM, 32'h0000_0000);
    check("normalize", acc, 40'h11_8000_0000);
    check("norm count", {35'h0, norm_sh}, 40'h1c);
  endtask : t_long
  // Subtracting and zeroing variants of the accumulation
  task automatic t_mac_var;
    wr(MACU_OFF_MODE, 1'b1, 16'h0000);
    load(40'h00_0000_0005);
    i_macu_cpu_model.mac(1'b0, 32'h0000_0006, 1'b1, 1'b0);
    check("unsigned sub", acc, 40'hff_ffff_ffff);
    rd("borrow flags", MACU_OFF_MODE, 1'b1, 16'h003e);
    i_macu_cpu_model.mac(1'b1, 32'h0000_0007, 1'b0, 1'b1);
    check("zeroed", {8'h00, acc[31:0]}, 40'h0007);
    rd("ovf dropped", MACU_OFF_MODE, 1'b1, 16'h003c);
    i_macu_cpu_model.mac(1'b1, 32'h0000_0009, 1'b1, 1'b0);
    check("signed sub", {8'h00, acc[31:0]}, 40'hffff_fffe);
  endtask : t_mac_var
  // Clock enable low freezes every register and the bus answer
  task automatic t_hold;
    @(posedge clk);
    clk_en <= 1'b0;
    i_macu_cpu_model.mac(1'b1, 32'h0000_0100);
    check("frozen acc", {8'h00, acc[31:0]}, 40'hffff_fffe);
    i_macu_cpu_model.sfr(1'b1, MACU_OFF_MODE, 1'b1, 16'h00c0, r);
    check("frozen answer", {38'h0, r[17:16]}, 40'h0);
    check("frozen mode", {32'h0, mode}, 40'h3c);
    clk_en <= 1'b1;
    rd("thawed mode", MACU_OFF_MODE, 1'b1, 16'h003c);
  endtask : t_hold
  // Reset in mid-run clears the accumulator and the carry
  task automatic t_reset;
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    check("reset acc", acc, 40'h00_0000_0000);
    check("reset mode", {32'h0, mode}, 40'h38);
    check("reset carry", {39'h0, carry}, 40'h0);
    nrst <= 1'b1;
    rd("top after reset", MACU_OFF_TOP, 1'b1, 16'h0000);
  endtask : t_reset
  task automatic finish_test;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_map;
    t_unsigned;
    t_signed;
    t_sat;
    t_alu;
    t_long;
    t_mac_var;
    t_hold;
    t_reset;
    finish_test;
  end
endmodule : mac_accumulator_unit_test
